/* hdl/i2c_bus_flag_start_control.sv */
`timescale 1ns/1ps
module i2c_bus_flag_start_control
#(
   parameter int DATA_W = 32
)
(
   // Clock and reset.
   input  wire logic                           core_clk_in,
   input  wire logic                           rstn_in,
   // APB slave.
   input  wire logic                           psel_in,
   input  wire logic                           penable_in,
   input  wire logic                           pwrite_in,
   input  wire logic [31:0]                    paddr_in,
   input  wire logic [DATA_W-1:0]              pwdata_in,
   output logic      [DATA_W-1:0]              prdata_out,
   output logic                                pready_out,
   output logic                                pslverr_out,
   // Bus lines and the start generator.
   input  wire logic                           scl_in,
   input  wire logic                           sda_in,
   input  wire logic                           start_attempt_fail_in,
   // Control towards the serial logic.
   output logic                                i2c_operation_enable_out,
   output logic                                start_request_out,
   output logic                                start_permit_out,
   output logic                                reservation_disable_out,
   output logic                                bus_busy_flag_out,
   output logic                                start_fail_flag_out,
   // Interrupt.
   output logic                                irq_out
);
   import i2c_flag_pkg::*;

   // ==========================================================
   // Elaboration check.
   generate
      if (DATA_W != 32)
      begin : g_bad_width
         $error("DATA_W must be 32");
      end
   endgenerate

   // ==========================================================
   // State.
   flag_mode_t       flag_mode;
   flag_mode_t       next_flag_mode;
   logic             op_en;
   logic             next_op_en;
   logic             start_req;
   logic             next_start_req;
   logic             permit;
   logic             next_permit;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] next_irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic [IRQ_W-1:0] next_irq_mask;
   logic             irq;
   logic [DATA_W-1:0] rdata;
   logic             ready;
   logic             slverr;
   line_t            line_meta;
   line_t            line_sync;
   line_t            line_prev;

   // ==========================================================
   // Start and stop detection on the synchronised lines.
   wire scl_high   = line_sync.scl & line_prev.scl;
   wire start_seen = scl_high & line_prev.sda & ~line_sync.sda;
   wire stop_seen  = scl_high & ~line_prev.sda & line_sync.sda;
   wire start_det  = start_seen & op_en;
   wire stop_det   = stop_seen & op_en;

   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         line_meta <= '1;
         line_sync <= '1;
      end
      else
      begin
         line_meta <= '{scl: scl_in, sda: sda_in};
         line_sync <= line_meta;
      end
   end

   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         line_prev <= '1;
      end
      else
      begin
         line_prev <= line_sync;
      end
   end

   // ==========================================================
   // APB decode.
   wire addr_ok     = (paddr_in[31:18] == 14'h0000) && (paddr_in[1:0] == 2'h0);
   wire hit_flag    = addr_ok && (paddr_in[17:2] == FLAG_MODE_IDX);
   wire hit_ctrl    = addr_ok && (paddr_in[17:2] == CONTROL_IDX);
   wire hit_stat    = addr_ok && (paddr_in[17:2] == IRQ_STATUS_IDX);
   wire hit_mask    = addr_ok && (paddr_in[17:2] == IRQ_MASK_IDX);
   wire hit_any     = hit_flag | hit_ctrl | hit_stat | hit_mask;
   wire setup       = psel_in & ~penable_in;
   wire access_done = psel_in & penable_in & ready;
   wire wr_fire     = access_done & pwrite_in;
   wire rd_fire     = access_done & ~pwrite_in;
   wire wr_flag     = wr_fire & hit_flag;
   wire wr_ctrl     = wr_fire & hit_ctrl;
   wire wr_mask     = wr_fire & hit_mask;
   wire rd_stat     = rd_fire & hit_stat;

   // ==========================================================
   // Read selection.
   wire [7:0] ctrl_view = {op_en, 5'h00, start_req, 1'b0};
   wire [DATA_W-1:0] read_word =
      hit_flag ? {24'h000000, flag_mode}                      :
      hit_ctrl ? {24'h000000, ctrl_view}                      :
      hit_stat ? {{(DATA_W-IRQ_W){1'b0}}, irq_status}         :
      hit_mask ? {{(DATA_W-IRQ_W){1'b0}}, irq_mask}           :
                 {DATA_W{1'b0}};

   // ==========================================================
   // Software strobes and the start failure event into the flag logic.
   wire enable_rise  = wr_ctrl & pwdata_in[CTRL_OP_EN_BIT] & ~op_en;
   wire sw_start_set = wr_ctrl & pwdata_in[CTRL_START_REQ_BIT];
   wire mode_write   = wr_flag & ~op_en;
   wire fail_event   = start_attempt_fail_in & op_en & flag_mode.reservation_disable;

   // ==========================================================
   // Control register next values.
   assign next_op_en = wr_ctrl ? pwdata_in[CTRL_OP_EN_BIT] : op_en;

   assign next_start_req = wr_ctrl ? (pwdata_in[CTRL_START_REQ_BIT] & pwdata_in[CTRL_OP_EN_BIT]) :
                           (start_req & op_en & ~fail_event);

   // ==========================================================
   // Flag and mode register next values.
   assign next_flag_mode.start_fail_flag =
      fail_event | (op_en & flag_mode.start_fail_flag & ~sw_start_set);

   assign next_flag_mode.bus_busy_flag =
      (enable_rise & ~flag_mode.initial_start_enable) |
      (op_en & (start_det | (flag_mode.bus_busy_flag & ~stop_det)));

   assign next_flag_mode.unused = 4'h0;

   assign next_flag_mode.initial_start_enable =
      ~start_det & (mode_write ? pwdata_in[FM_INIT_START_BIT] :
                                 flag_mode.initial_start_enable);

   assign next_flag_mode.reservation_disable =
      mode_write ? pwdata_in[FM_RSV_DIS_BIT] : flag_mode.reservation_disable;

   // ==========================================================
   // Start permission after enabling.
   assign next_permit =
      (enable_rise & flag_mode.initial_start_enable) |
      (op_en & (permit | stop_det));

   // ==========================================================
   // Interrupt status, one sticky bit per event; an event wins over the read clear.
   wire [IRQ_W-1:0] irq_event;
   assign irq_event[IRQ_START_BIT] = start_det;
   assign irq_event[IRQ_STOP_BIT]  = stop_det;
   assign irq_event[IRQ_FAIL_BIT]  = fail_event;

   genvar gi;
   generate
      for (gi = 0; gi < IRQ_W; gi++)
      begin : g_irq
         assign next_irq_status[gi] = irq_event[gi] |
                                      (irq_status[gi] & ~(rd_stat & rdata[gi]));
      end
   endgenerate

   assign next_irq_mask = wr_mask ? pwdata_in[IRQ_W-1:0] : irq_mask;

   // ==========================================================
   // Flag and mode register.
   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         flag_mode <= flag_mode_t'(FLAG_MODE_RST);
      end
      else
      begin
         flag_mode <= next_flag_mode;
      end
   end

   // ==========================================================
   // Control register: operation enable and start request.
   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         op_en <= CONTROL_RST[CTRL_OP_EN_BIT];
      end
      else
      begin
         op_en <= next_op_en;
      end
   end

   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         start_req <= CONTROL_RST[CTRL_START_REQ_BIT];
      end
      else
      begin
         start_req <= next_start_req;
      end
   end

   // ==========================================================
   // Start permission.
   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         permit <= 1'b0;
      end
      else
      begin
         permit <= next_permit;
      end
   end

   // ==========================================================
   // Interrupt status, mask and line.
   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         irq_status <= IRQ_RST;
      end
      else
      begin
         irq_status <= next_irq_status;
      end
   end

   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         irq_mask <= IRQ_RST;
      end
      else
      begin
         irq_mask <= next_irq_mask;
      end
   end

   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |(next_irq_status & next_irq_mask);
      end
   end

   // ==========================================================
   // APB answer: one wait-free access phase after each setup.
   wire [DATA_W-1:0] next_rdata = setup       ? (pwrite_in ? {DATA_W{1'b0}} : read_word) :
                                  access_done ? {DATA_W{1'b0}}                           :
                                                rdata;

   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         ready <= 1'b0;
      end
      else
      begin
         ready <= setup;
      end
   end

   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         slverr <= 1'b0;
      end
      else
      begin
         slverr <= setup & ~hit_any;
      end
   end

   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         rdata <= '0;
      end
      else
      begin
         rdata <= next_rdata;
      end
   end

   // ==========================================================
   // Outputs.
   assign prdata_out               = rdata;
   assign pready_out               = ready;
   assign pslverr_out              = slverr;
   assign i2c_operation_enable_out = op_en;
   assign start_request_out        = start_req;
   assign start_permit_out         = permit;
   assign reservation_disable_out  = flag_mode.reservation_disable;
   assign bus_busy_flag_out        = flag_mode.bus_busy_flag;
   assign start_fail_flag_out      = flag_mode.start_fail_flag;
   assign irq_out                  = irq;

endmodule

/* hdl/i2c_flag_pkg.sv */
package i2c_flag_pkg;

   // ==========================================================
   // Register indices; the byte address is four times the index.
   localparam logic [15:0] FLAG_MODE_IDX  = 16'hffab;
   localparam logic [15:0] CONTROL_IDX    = 16'hffac;
   localparam logic [15:0] IRQ_STATUS_IDX = 16'hffad;
   localparam logic [15:0] IRQ_MASK_IDX   = 16'hffae;

   // ==========================================================
   // Field positions of the flag and mode register.
   localparam int unsigned FM_START_FAIL_BIT = 7;
   localparam int unsigned FM_BUS_BUSY_BIT   = 6;
   localparam int unsigned FM_INIT_START_BIT = 1;
   localparam int unsigned FM_RSV_DIS_BIT    = 0;

   // ==========================================================
   // Field positions of the control register.
   localparam int unsigned CTRL_OP_EN_BIT     = 7;
   localparam int unsigned CTRL_START_REQ_BIT = 1;

   // ==========================================================
   // Interrupt event bits, shared by status and mask.
   localparam int unsigned IRQ_W         = 3;
   localparam int unsigned IRQ_START_BIT = 0;
   localparam int unsigned IRQ_STOP_BIT  = 1;
   localparam int unsigned IRQ_FAIL_BIT  = 2;

   // ==========================================================
   // Reset values.
   localparam logic [7:0]       FLAG_MODE_RST = 8'h00;
   localparam logic [7:0]       CONTROL_RST   = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_RST       = 3'h0;

   // ==========================================================
   // Layout of the flag and mode register.
   typedef struct packed {
      logic       start_fail_flag;
      logic       bus_busy_flag;
      logic [3:0] unused;
      logic       initial_start_enable;
      logic       reservation_disable;
   } flag_mode_t;

   // ==========================================================
   // Sampled bus line levels.
   typedef struct packed {
      logic scl;
      logic sda;
   } line_t;

endpackage

/* bench/i2c_flag_props.sv */
`timescale 1ns/1ps
// ==========================================
// Checker on the flag block ports.
module i2c_flag_props
(
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic start_attempt_fail_in,
   input wire logic pready_out,
   input wire logic i2c_operation_enable_out,
   input wire logic start_permit_out,
   input wire logic reservation_disable_out,
   input wire logic bus_busy_flag_out,
   input wire logic start_fail_flag_out,
   input wire logic start_request_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);
   AST_PREADY_NEXT: assert property (psel_in && !penable_in |=> pready_out)
      else $error("no pready");
   AST_BUSY_OFF: assert property (!i2c_operation_enable_out [*2] |-> !bus_busy_flag_out)
      else $error("busy while off");
   AST_FAIL_OFF: assert property (!i2c_operation_enable_out [*2] |-> !start_fail_flag_out)
      else $error("fail while off");
   AST_PERMIT_OFF: assert property (!i2c_operation_enable_out [*2] |-> !start_permit_out)
      else $error("permit while off");
   AST_FAIL_SET: assert property (start_attempt_fail_in && i2c_operation_enable_out && reservation_disable_out
      |=> start_fail_flag_out && !start_request_out)
      else $error("fail not taken");
   AST_FAIL_CAUSE: assert property ($rose(start_fail_flag_out)
      |-> $past(start_attempt_fail_in && reservation_disable_out))
      else $error("fail without cause");
   AST_RSV_SW_ONLY: assert property (!(psel_in && penable_in && pwrite_in)
      |=> $stable(reservation_disable_out))
      else $error("reservation moved");
   AST_RSV_LOCK: assert property (i2c_operation_enable_out |=> $stable(reservation_disable_out))
      else $error("reservation written while on");
endmodule
bind i2c_bus_flag_start_control i2c_flag_props u_i2c_flag_props (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .start_attempt_fail_in(start_attempt_fail_in),
   .pready_out(pready_out), .i2c_operation_enable_out(i2c_operation_enable_out), .start_permit_out(start_permit_out),
   .reservation_disable_out(reservation_disable_out), .bus_busy_flag_out(bus_busy_flag_out),
   .start_fail_flag_out(start_fail_flag_out), .start_request_out(start_request_out));

/* bench/i2c_far_bus_model.sv */
`timescale 1ns/1ps
// ==========================================
// Another master on the bus; lines idle high and move 1 ns off the core clock edges.
module i2c_far_bus_model
(
   output logic scl_out,
   output logic sda_out
);
   initial
   begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   task automatic send_start();
      #1;
      sda_out = 1'b0;
      #40;
      scl_out = 1'b0;
      #40;
   endtask
   task automatic send_stop();
      #1;
      scl_out = 1'b0;
      sda_out = 1'b0;
      #40;
      scl_out = 1'b1;
      #40;
      sda_out = 1'b1;
      #40;
   endtask
endmodule

/* bench/i2c_bus_flag_start_control_tb.sv */
`timescale 1ns/1ps
// ==========================================
// Bench for the flag and mode block.
module i2c_bus_flag_start_control_tb;
   import i2c_flag_pkg::*;
   logic        core_clk_in = 1'b0;
   logic        rstn_in     = 1'b0;
   logic        psel_in     = 1'b0;
   logic        penable_in  = 1'b0;
   logic        pwrite_in   = 1'b0;
   logic        fail_in     = 1'b0;
   logic [31:0] paddr_in    = 32'h0;
   logic [31:0] pwdata_in   = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, err, op_en, req, permit, rsv, busy, fail, irq, scl, sda;
   int          failures    = 0;
   int          checks_done = 0;
   localparam logic [31:0] FLAG_A = {14'h0, FLAG_MODE_IDX, 2'h0};
   localparam logic [31:0] CTRL_A = {14'h0, CONTROL_IDX, 2'h0};
   localparam logic [31:0] STAT_A = {14'h0, IRQ_STATUS_IDX, 2'h0};
   localparam logic [31:0] MASK_A = {14'h0, IRQ_MASK_IDX, 2'h0};
   always #5 core_clk_in = ~core_clk_in;
   i2c_far_bus_model u_i2c_far_bus_model (.scl_out(scl), .sda_out(sda));
   i2c_bus_flag_start_control u_i2c_bus_flag_start_control (
      .core_clk_in(core_clk_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .scl_in(scl), .sda_in(sda), .start_attempt_fail_in(fail_in),
      .i2c_operation_enable_out(op_en), .start_request_out(req), .start_permit_out(permit),
      .reservation_disable_out(rsv), .bus_busy_flag_out(busy), .start_fail_flag_out(fail), .irq_out(irq));
   task automatic complete_run();
      $display("failures %0d checks %0d", failures, checks_done);
      if (failures == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [31:0] a, input logic [7:0] d, output logic [31:0] r);
      int n;
      psel_in    <= 1'b1;
      pwrite_in  <= wr;
      paddr_in   <= a;
      pwdata_in  <= {24'h0, d};
      @(posedge core_clk_in);
      penable_in <= 1'b1;
      n = 0;
      do
      begin
         @(posedge core_clk_in);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
      begin
         failures++;
         complete_run();
      end
      r = prdata;
      err = pslverr;
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
   endtask
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask
   task automatic rd(input string what, input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] r;
      apb(1'b0, a, 8'h00, r);
      chk(what, exp, r);
   endtask
   task automatic pulse_fail();
      fail_in <= 1'b1;
      @(posedge core_clk_in);
      fail_in <= 1'b0;
      repeat (3) @(posedge core_clk_in);
   endtask
   task automatic check_reset();
      rd("flag", FLAG_A, 32'h0);
      rd("ctrl", CTRL_A, 32'h0);
      rd("unmapped", 32'h100, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
   endtask
   task automatic check_early_start();
      wr(FLAG_A, 8'hff);
      rd("flag wr", FLAG_A, 32'h03);
      chk("rsv", 32'h1, {31'h0, rsv});
      wr(CTRL_A, 8'h80);
      wr(FLAG_A, 8'h00);
      rd("flag lock", FLAG_A, 32'h03);
      chk("permit", 32'h1, {31'h0, permit});
      chk("idle", 32'h3, {30'h0, scl, sda});
      wr(CTRL_A, 8'h82);
      pulse_fail();
      chk("fail req", 32'h2, {30'h0, fail, req});
      wr(CTRL_A, 8'h82);
      chk("fail clr", 32'h0, {31'h0, fail});
      u_i2c_far_bus_model.send_start();
      repeat (6) @(posedge core_clk_in);
      rd("start", FLAG_A, 32'h41);
      u_i2c_far_bus_model.send_stop();
      repeat (6) @(posedge core_clk_in);
      rd("stop", FLAG_A, 32'h01);
      u_i2c_far_bus_model.send_start();
      @(posedge core_clk_in);
      pulse_fail();
      wr(CTRL_A, 8'h00);
      rd("off", FLAG_A, 32'h01);
   endtask
   task automatic check_wait_stop();
      wr(FLAG_A, 8'h00);
      wr(CTRL_A, 8'h80);
      rd("busy", FLAG_A, 32'h40);
      chk("busy pin", 32'h3, {30'h0, busy, op_en});
      chk("no permit", 32'h0, {31'h0, permit});
      pulse_fail();
      chk("rsv on", 32'h0, {31'h0, fail});
      u_i2c_far_bus_model.send_stop();
      repeat (6) @(posedge core_clk_in);
      chk("permit", 32'h1, {31'h0, permit});
      rd("released", FLAG_A, 32'h00);
      chk("busy pin off", 32'h0, {31'h0, busy});
   endtask
   task automatic check_mid_reset();
      wr(CTRL_A, 8'h00);
      wr(FLAG_A, 8'h03);
      wr(CTRL_A, 8'h80);
      chk("permit set", 32'h1, {31'h0, permit});
      rstn_in <= 1'b0;
      repeat (3) @(posedge core_clk_in);
      rstn_in <= 1'b1;
      @(posedge core_clk_in);
      rd("flag rst", FLAG_A, 32'h00);
      rd("mask rst", MASK_A, 32'h00);
      chk("rst pins", 32'h0, {28'h0, op_en, permit, rsv, irq});
   endtask
   task automatic check_irq();
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(MASK_A, 8'h07);
      chk("irq", 32'h1, {31'h0, irq});
      rd("status", STAT_A, 32'h07);
      chk("irq clr", 32'h0, {31'h0, irq});
   endtask
   initial
   begin
      repeat (20) @(posedge core_clk_in);
      rstn_in <= 1'b1;
      @(posedge core_clk_in);
      check_reset();
      check_early_start();
      check_wait_stop();
      check_irq();
      check_mid_reset();
      complete_run();
   end
endmodule
